// File: core/gsp_pkg.sv
// Shared constants for the genset stop and protection sequencer
package gsp_pkg;
	// Register byte offsets
	localparam logic [7:0] ADDR_CONFIG = 8'h00;
	localparam logic [7:0] ADDR_COOLDOWN = 8'h04;
	localparam logic [7:0] ADDR_OVERSPEED = 8'h08;
	localparam logic [7:0] ADDR_ACCESS = 8'h0C;
	localparam logic [7:0] ADDR_CRANK_TERM = 8'h10;
	localparam logic [7:0] ADDR_OIL = 8'h14;
	localparam logic [7:0] ADDR_COOL = 8'h18;
	localparam logic [7:0] ADDR_DELAYS = 8'h1C;
	localparam logic [7:0] ADDR_HOURS = 8'h20;
	localparam logic [7:0] ADDR_STATUS = 8'h24;
	localparam logic [7:0] ADDR_CMD = 8'h28;
	// CONFIG fields
	localparam int CFG_ESTOP_HIGH = 0;
	localparam int CFG_CAN_STOP = 1;
	localparam int CFG_RESP_LSB = 2;
	localparam logic [31:0] CONFIG_RST = 32'h0000_00FE;
	// Event responses, two bits per event: oil, coolant, external
	localparam logic [1:0] RESP_OFF = 2'h0;
	localparam logic [1:0] RESP_WARN = 2'h1;
	localparam logic [1:0] RESP_SOFT = 2'h2;
	localparam logic [1:0] RESP_HARD = 2'h3;
	// ACCESS fields
	localparam logic [1:0] LEVEL_THREE = 2'h3;
	localparam int ACC_SRC_TOOL = 2;
	// Reset values of setpoints
	localparam logic [15:0] COOLDOWN_RST = 16'h012C;
	localparam logic [15:0] OVERSPEED_RST = 16'h0852;
	localparam logic [15:0] CRANK_TERM_RST = 16'h0190;
	localparam logic [31:0] OIL_RST = 32'h0064_00C8;
	localparam logic [31:0] COOL_RST = 32'h006E_0064;
	localparam logic [23:0] DELAYS_RST = 24'h0A_0A_0A;
	// Coolant shutdown threshold floor, degrees C
	localparam logic [15:0] COOL_SD_MIN = 16'h0031;
	// Timing
	localparam int CLK_PERIOD_NS = 40;
	localparam int SEC_NS = 1000000000;
	localparam int SEC_CYCLES_DEF = SEC_NS / CLK_PERIOD_NS;
	localparam logic [7:0] STOP_HOLD_S = 8'h05;
	localparam logic [8:0] TENTH_HOUR_S = 9'h168;
	// Hours meter in tenths: 596523.2 h
	localparam logic [22:0] HOURS_MAX = 23'h5B05B0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: core/gsp_sequencer.sv
// Stop, protection and hours logic of a generator set controller
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
// How it works
// - Stop runs cooldown; zero duration stops immediately
// - Stop held five seconds raises bypass prompt
// - OK on prompt ends cooldown, stops
// - Escape on prompt lets cooldown finish
// - Fuel output drops when cooldown ends
// - Stop request sent on CAN if configured
// - Persistent threshold or shutdown event starts shutdown
// - Response picks soft or hard shutdown
// - Disabled or warning response never stops engine
// - Active switch inputs lock out panel keys
// - Emergency stop polarity is configurable
// - Overspeed trips at once above threshold
// - Oil and coolant warn and shut separately
// - Oil, coolant shutdowns wait own delay
// - Protection timer masks them until it expires
// - Timer starts at crank terminate speed
// - Coolant shutdown threshold rejected below 49C
// - Hours count only above crank terminate
// - Hours update never lowers value
// - Hours update panel only, level three
// - Hours meter saturates at maximum
// - Overspeed change needs level three on panel
module gsp_sequencer #(
	parameter int SEC_CYCLES = gsp_pkg::SEC_CYCLES_DEF
) (
	input wire logic aclk, // bus and logic clock
	input wire logic aresetn, // synchronous reset, low
	input wire logic [7:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // byte strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [7:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic [15:0] engine_speed, // measured rpm
	input wire logic [15:0] oil_pressure, // kPa
	input wire logic [15:0] coolant_temp, // degrees C
	input wire logic estop_in, // emergency stop pin, raw level
	input wire logic ext_shutdown, // other shutdown event present
	input wire logic run_key, // panel run key
	input wire logic stop_key, // panel stop key, level while held
	input wire logic ok_key, // panel OK key
	input wire logic esc_key, // panel escape key
	input wire logic engine_control_switch_auto, // switch input, auto
	input wire logic engine_control_switch_run, // switch input, run
	input wire logic engine_control_switch_stop, // switch input, stop
	output logic fuel_out, // fuel injection output
	output logic can_stop_req, // one-cycle CAN stop request
	output logic bypass_prompt, // cooldown bypass prompt shown
	output logic oil_warn, // low oil pressure warning
	output logic cool_warn // high coolant temperature warning
);
	typedef enum logic [1:0] {ST_STOPPED, ST_RUN, ST_COOL} gsp_state_e;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a[7:2] == off[7:2]);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Register bus
	logic aw_q, w_q, bvalid_q, rvalid_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q, rdata_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] config_q, oil_q, cool_q;
	logic [15:0] cooldown_q, overspeed_q, crank_term_q;
	logic [23:0] delays_q;
	logic [2:0] access_q;
	logic [22:0] hours_q;
	wire wr_fire = aw_q & w_q & ~bvalid_q;
	wire full_word = &s_axi_wstrb;
	wire level3 = (access_q[1:0] == gsp_pkg::LEVEL_THREE);
	wire from_tool = access_q[gsp_pkg::ACC_SRC_TOOL];
	wire os_ok = from_tool | level3;
	wire cool_ok = wdata_q[31:16] >= gsp_pkg::COOL_SD_MIN;
	wire hours_ok = ~from_tool & level3 & (wdata_q[22:0] >= hours_q)
		& (wdata_q[22:0] <= gsp_pkg::HOURS_MAX) & (wdata_q[31:23] == 9'h000);
	wire wr_os = wr_fire & hit(awaddr_q, gsp_pkg::ADDR_OVERSPEED) & os_ok;
	wire wr_cool = wr_fire & hit(awaddr_q, gsp_pkg::ADDR_COOL) & cool_ok;
	wire wr_hours = wr_fire & hit(awaddr_q, gsp_pkg::ADDR_HOURS) & hours_ok;
	wire wr_cmd = wr_fire & hit(awaddr_q, gsp_pkg::ADDR_CMD);
	wire wr_plain = hit(awaddr_q, gsp_pkg::ADDR_CONFIG) | hit(awaddr_q, gsp_pkg::ADDR_COOLDOWN)
		| hit(awaddr_q, gsp_pkg::ADDR_ACCESS) | hit(awaddr_q, gsp_pkg::ADDR_CRANK_TERM)
		| hit(awaddr_q, gsp_pkg::ADDR_OIL) | hit(awaddr_q, gsp_pkg::ADDR_DELAYS) | wr_cmd;
	wire wr_good = wr_plain | wr_os | wr_cool | wr_hours;

	assign s_axi_awready = ~aw_q & ~bvalid_q;
	assign s_axi_wready = ~w_q & ~bvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = ~rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_q <= 1'b0;
			w_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= gsp_pkg::RESP_OKAY;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_q <= 1'b1;
				wdata_q <= s_axi_wdata;
			end
			if (wr_fire)
			begin
				aw_q <= 1'b0;
				w_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= (wr_good && full_word) ? gsp_pkg::RESP_OKAY : gsp_pkg::RESP_SLVERR;
			end
			else if (bvalid_q && s_axi_bready)
				bvalid_q <= 1'b0;
		end
	end

	// Partial-word writes are refused whole, so a setpoint never holds half a value
	wire wr_en = wr_fire & full_word;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			config_q <= gsp_pkg::CONFIG_RST;
			cooldown_q <= gsp_pkg::COOLDOWN_RST;
			overspeed_q <= gsp_pkg::OVERSPEED_RST;
			access_q <= 3'h0;
			crank_term_q <= gsp_pkg::CRANK_TERM_RST;
			oil_q <= gsp_pkg::OIL_RST;
			cool_q <= gsp_pkg::COOL_RST;
			delays_q <= gsp_pkg::DELAYS_RST;
		end
		else if (wr_en)
		begin
			if (hit(awaddr_q, gsp_pkg::ADDR_CONFIG))
				config_q <= wdata_q;
			if (hit(awaddr_q, gsp_pkg::ADDR_COOLDOWN))
				cooldown_q <= wdata_q[15:0];
			if (wr_os)
				overspeed_q <= wdata_q[15:0];
			if (hit(awaddr_q, gsp_pkg::ADDR_ACCESS))
				access_q <= wdata_q[2:0];
			if (hit(awaddr_q, gsp_pkg::ADDR_CRANK_TERM))
				crank_term_q <= wdata_q[15:0];
			if (hit(awaddr_q, gsp_pkg::ADDR_OIL))
				oil_q <= wdata_q;
			if (wr_cool)
				cool_q <= wdata_q;
			if (hit(awaddr_q, gsp_pkg::ADDR_DELAYS))
				delays_q <= wdata_q[23:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Seconds tick and protection channels
	logic [31:0] sec_cnt_q;
	wire tick = (sec_cnt_q == SEC_CYCLES - 1);
	always_ff @(posedge aclk)
	begin
		if (!aresetn || tick)
			sec_cnt_q <= 32'h0000_0000;
		else
			sec_cnt_q <= sec_cnt_q + 32'h0000_0001;
	end

	gsp_state_e state_q, state_d;
	wire running = (state_q != ST_STOPPED);
	wire above_ct = engine_speed > crank_term_q;
	logic [7:0] fpt_cnt_q;
	logic fpt_done_q;
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !running)
		begin
			fpt_cnt_q <= 8'h00;
			fpt_done_q <= 1'b0;
		end
		else if (engine_speed >= crank_term_q && tick && !fpt_done_q)
		begin
			fpt_cnt_q <= fpt_cnt_q + 8'h01;
			fpt_done_q <= (fpt_cnt_q + 8'h01) >= delays_q[23:16];
		end
	end
	wire fpt_open = running & fpt_done_q;

	// Channel 0 is low oil pressure, channel 1 is high coolant temperature
	logic [1:0] warn_c, sd_cond, sd_trip;
	logic [7:0] sd_cnt_q [2];
	assign warn_c[0] = oil_pressure < oil_q[15:0];
	assign warn_c[1] = coolant_temp > cool_q[15:0];
	assign sd_cond[0] = oil_pressure < oil_q[31:16];
	assign sd_cond[1] = coolant_temp > cool_q[31:16];
	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_chan
			wire [7:0] dly = delays_q[8*g +: 8];
			always_ff @(posedge aclk)
			begin
				if (!aresetn || !sd_cond[g] || !fpt_open)
					sd_cnt_q[g] <= 8'h00;
				else if (tick && sd_cnt_q[g] < dly)
					sd_cnt_q[g] <= sd_cnt_q[g] + 8'h01;
			end
			assign sd_trip[g] = sd_cond[g] & fpt_open & (sd_cnt_q[g] >= dly);
		end
	endgenerate

	wire [1:0] resp_oil = config_q[gsp_pkg::CFG_RESP_LSB +: 2];
	wire [1:0] resp_cool = config_q[gsp_pkg::CFG_RESP_LSB + 2 +: 2];
	wire [1:0] resp_ext = config_q[gsp_pkg::CFG_RESP_LSB + 4 +: 2];
	wire estop = estop_in ~^ config_q[gsp_pkg::CFG_ESTOP_HIGH];
	wire overspeed = running & (engine_speed > overspeed_q);
	wire sd_hard = estop | overspeed | (sd_trip[0] & (resp_oil == gsp_pkg::RESP_HARD))
		| (sd_trip[1] & (resp_cool == gsp_pkg::RESP_HARD))
		| (running & ext_shutdown & (resp_ext == gsp_pkg::RESP_HARD));
	wire sd_soft = (sd_trip[0] & (resp_oil == gsp_pkg::RESP_SOFT))
		| (sd_trip[1] & (resp_cool == gsp_pkg::RESP_SOFT))
		| (running & ext_shutdown & (resp_ext == gsp_pkg::RESP_SOFT));

	// Latched shutdown blocks restart; a new event wins over the reset command
	logic latched_q;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			latched_q <= 1'b0;
		else if (sd_hard || sd_soft)
			latched_q <= 1'b1;
		else if (wr_cmd && wr_en && wdata_q[0])
			latched_q <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// Start and stop sequencing
	wire switch_held = engine_control_switch_auto | engine_control_switch_run | engine_control_switch_stop;
	wire panel_ok = ~switch_held;
	wire start_req = (run_key & panel_ok) | engine_control_switch_run;
	wire stop_req = (stop_key & panel_ok) | engine_control_switch_stop;
	logic [15:0] cool_cnt_q;
	logic [7:0] hold_cnt_q;
	logic prompt_q, fuel_q, can_q;
	wire cool_done = (cool_cnt_q >= cooldown_q);
	wire bypass = prompt_q & ok_key & panel_ok;
	wire decline = prompt_q & esc_key & panel_ok;

	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			ST_STOPPED:
				if (start_req && !latched_q && !sd_hard && !sd_soft)
					state_d = ST_RUN;
			ST_RUN:
				if (sd_hard)
					state_d = ST_STOPPED;
				else if (sd_soft || stop_req)
					state_d = (cooldown_q == 16'h0000) ? ST_STOPPED : ST_COOL;
			ST_COOL:
				if (sd_hard || cool_done || bypass)
					state_d = ST_STOPPED;
		endcase
	end
	wire stop_now = running & (state_d == ST_STOPPED);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_q <= ST_STOPPED;
			fuel_q <= 1'b0;
			can_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			fuel_q <= (state_d != ST_STOPPED);
			can_q <= stop_now & config_q[gsp_pkg::CFG_CAN_STOP];
		end
	end

	// Cooldown counts whole seconds from entry; escape does not stop it
	always_ff @(posedge aclk)
	begin
		if (!aresetn || state_q != ST_COOL)
			cool_cnt_q <= 16'h0000;
		else if (tick && !cool_done)
			cool_cnt_q <= cool_cnt_q + 16'h0001;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn || state_q != ST_COOL || !(stop_key && panel_ok))
			hold_cnt_q <= 8'h00;
		else if (tick && hold_cnt_q < gsp_pkg::STOP_HOLD_S)
			hold_cnt_q <= hold_cnt_q + 8'h01;
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn || state_d != ST_COOL || decline)
			prompt_q <= 1'b0;
		else if (hold_cnt_q == gsp_pkg::STOP_HOLD_S)
			prompt_q <= 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////
	// Operating hours meter, tenths of an hour
	logic [8:0] hr_sec_q;
	wire at_max = (hours_q == gsp_pkg::HOURS_MAX);
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			hr_sec_q <= 9'h000;
			hours_q <= 23'h000000;
		end
		else if (wr_hours && full_word)
			hours_q <= wdata_q[22:0];
		else if (tick && above_ct && !at_max)
		begin
			if (hr_sec_q == gsp_pkg::TENTH_HOUR_S - 9'h001)
			begin
				hr_sec_q <= 9'h000;
				hours_q <= hours_q + 23'h000001;
			end
			else
				hr_sec_q <= hr_sec_q + 9'h001;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read path
	wire [31:0] status_w = {24'h000000, sd_trip, latched_q, prompt_q, fpt_done_q, fuel_q,
		state_q == ST_COOL, state_q == ST_RUN};
	logic [31:0] rd_mux;
	assign rd_mux = hit(s_axi_araddr, gsp_pkg::ADDR_CONFIG) ? config_q
		: hit(s_axi_araddr, gsp_pkg::ADDR_COOLDOWN) ? {16'h0000, cooldown_q}
		: hit(s_axi_araddr, gsp_pkg::ADDR_OVERSPEED) ? {16'h0000, overspeed_q}
		: hit(s_axi_araddr, gsp_pkg::ADDR_ACCESS) ? {29'h00000000, access_q}
		: hit(s_axi_araddr, gsp_pkg::ADDR_CRANK_TERM) ? {16'h0000, crank_term_q}
		: hit(s_axi_araddr, gsp_pkg::ADDR_OIL) ? oil_q
		: hit(s_axi_araddr, gsp_pkg::ADDR_COOL) ? cool_q
		: hit(s_axi_araddr, gsp_pkg::ADDR_DELAYS) ? {8'h00, delays_q}
		: hit(s_axi_araddr, gsp_pkg::ADDR_HOURS) ? {9'h000, hours_q}
		: hit(s_axi_araddr, gsp_pkg::ADDR_STATUS) ? status_w : 32'h0000_0000;
	wire rd_known = hit(s_axi_araddr, gsp_pkg::ADDR_CMD) | (s_axi_araddr <= gsp_pkg::ADDR_STATUS);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= gsp_pkg::RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_q <= 1'b1;
			rdata_q <= rd_mux;
			rresp_q <= rd_known ? gsp_pkg::RESP_OKAY : gsp_pkg::RESP_SLVERR;
		end
		else if (s_axi_rready)
			rvalid_q <= 1'b0;
	end

	assign fuel_out = fuel_q;
	assign can_stop_req = can_q;
	assign bypass_prompt = prompt_q;
	assign oil_warn = warn_c[0] & running & (resp_oil != gsp_pkg::RESP_OFF);
	assign cool_warn = warn_c[1] & running & (resp_cool != gsp_pkg::RESP_OFF);

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_stop_enter;
		state_q == ST_RUN && stop_req && !sd_hard && !sd_soft;
	endsequence
	zero_cooldown_a: assert property (s_stop_enter and cooldown_q == 16'h0000 |=> !fuel_out)
		else $error("zero cooldown did not stop at once");
	cool_enter_a: assert property (s_stop_enter and cooldown_q != 16'h0000 |=> state_q == ST_COOL && fuel_out)
		else $error("cooldown not entered");
	prompt_hold_a: assert property ($rose(prompt_q) |-> $past(hold_cnt_q) == gsp_pkg::STOP_HOLD_S)
		else $error("prompt raised without full hold");
	bypass_stop_a: assert property (bypass && !sd_hard |=> !fuel_out ##1 !fuel_out)
		else $error("bypass did not end cooldown");
	decline_keep_a: assert property (state_q == ST_COOL && decline && !cool_done && !sd_hard |=> state_q == ST_COOL)
		else $error("decline ended cooldown");
	can_pulse_a: assert property ($fell(fuel_out) && config_q[gsp_pkg::CFG_CAN_STOP] |-> can_stop_req ##1 !can_stop_req)
		else $error("CAN stop missing at fuel drop");
	overspeed_a: assert property (overspeed |=> !fuel_out)
		else $error("overspeed did not stop engine");
	warn_no_stop_a: assert property (state_q == ST_RUN && !estop && !overspeed && !stop_req
		&& (!ext_shutdown || resp_ext <= gsp_pkg::RESP_WARN)
		&& resp_oil <= gsp_pkg::RESP_WARN && resp_cool <= gsp_pkg::RESP_WARN |=> state_q == ST_RUN)
		else $error("warning response stopped engine");
	fpt_mask_a: assert property (!fpt_open |-> sd_trip == 2'b00 ##1 (sd_cnt_q[0] | sd_cnt_q[1]) == 8'h00)
		else $error("shutdown passed the protection timer");
	hours_mono_a: assert property (hours_q != $past(hours_q) |-> hours_q > $past(hours_q) && hours_q <= gsp_pkg::HOURS_MAX)
		else $error("hours decreased or passed maximum");
	keys_locked_a: assert property (state_q == ST_STOPPED && switch_held && !engine_control_switch_run |=> state_q == ST_STOPPED)
		else $error("panel key acted while switch held");
endmodule

// File: test/genset_stop_protection_sequencer_test.sv
// Self-checking bench for the genset stop and protection sequencer
`timescale 1ns/1ns
module genset_stop_protection_sequencer_test;
	localparam int SC = 10;
	localparam logic [1:0] OK = gsp_pkg::RESP_OKAY;
	localparam logic [1:0] ER = gsp_pkg::RESP_SLVERR;
	localparam logic [31:0] HMAX = {9'h000, gsp_pkg::HOURS_MAX};
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, estop_in, ext_shutdown, run_key, stop_key;
	logic ok_key, esc_key, engine_control_switch_auto, engine_control_switch_run, engine_control_switch_stop;
	logic fuel_out, can_stop_req, bypass_prompt, oil_warn, cool_warn, oil_f, cool_f, eh;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, lf, hv;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [15:0] engine_speed, oil_pressure, coolant_temp, oil_v, cool_v;
	int stops, sv, fails, total_checks, cyc, n;

	gsp_sequencer #(.SEC_CYCLES(SC)) i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.engine_speed, .oil_pressure, .coolant_temp, .estop_in, .ext_shutdown, .run_key, .stop_key, .ok_key,
		.esc_key, .engine_control_switch_auto, .engine_control_switch_run, .engine_control_switch_stop,
		.fuel_out, .can_stop_req, .bypass_prompt, .oil_warn, .cool_warn);
	gsp_engine_model i_eng (.aclk, .fuel_out, .can_stop_req, .engine_speed, .stops);

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [31:0] dflt(input int i);
		case (i)
			0: return gsp_pkg::CONFIG_RST;
			1: return {16'h0000, gsp_pkg::COOLDOWN_RST};
			2: return {16'h0000, gsp_pkg::OVERSPEED_RST};
			4: return {16'h0000, gsp_pkg::CRANK_TERM_RST};
			5: return gsp_pkg::OIL_RST;
			6: return gsp_pkg::COOL_RST;
			7: return {8'h00, gsp_pkg::DELAYS_RST};
			default: return 32'h0000_0000;
		endcase
	endfunction
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic ok, input string m);
		total_checks++;
		if (ok !== 1'b1)
		begin
			fails++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask
	// Ready is sampled on the falling edge, where no design output moves
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ah, wh;
		@(posedge aclk);
		{s_axi_awaddr, s_axi_wdata} <= {a, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		ah = 1'b0;
		wh = 1'b0;
		while (!(ah && wh))
		begin
			@(negedge aclk);
			ah = ah || s_axi_awready === 1'b1;
			wh = wh || s_axi_wready === 1'b1;
			@(posedge aclk);
			if (ah)
				s_axi_awvalid <= 1'b0;
			if (wh)
				s_axi_wvalid <= 1'b0;
		end
		do
			@(negedge aclk);
		while (s_axi_bvalid !== 1'b1);
		chk(s_axi_bresp === er, "bresp");
		@(posedge aclk);
		s_axi_bready <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do
			@(negedge aclk);
		while (s_axi_arready !== 1'b1);
		@(posedge aclk);
		s_axi_arvalid <= 1'b0;
		do
			@(negedge aclk);
		while (s_axi_rvalid !== 1'b1);
		chk(s_axi_rdata === ed && s_axi_rresp === er, "read");
		@(posedge aclk);
		s_axi_rready <= 1'b0;
	endtask
	// Keys: 0 run, 1 stop, 2 ok, 3 escape, 4 switch run, 5 switch stop
	task automatic kp(input int k);
		@(posedge aclk);
		{run_key, stop_key, ok_key, esc_key, engine_control_switch_run, engine_control_switch_stop} <= 6'h20 >> k;
		@(posedge aclk);
		{run_key, stop_key, ok_key, esc_key, engine_control_switch_run, engine_control_switch_stop} <= 6'h00;
	endtask
	task automatic fw(input logic v, input int lo, input int hi, input string m);
		#1;
		n = 0;
		while (fuel_out !== v && n <= hi)
		begin
			@(posedge aclk);
			#1;
			n++;
		end
		chk(n >= lo && n <= hi, m);
	endtask
	task automatic start(input int k);
		kp(k);
		fw(1'b1, 0, 4, "start");
	endtask
	// A trip latches, so the cause is removed before the clear command
	task automatic trip(input int lo, input int hi, input string m);
		fw(1'b0, lo, hi, m);
		@(posedge aclk);
		{ext_shutdown, oil_f, cool_f, estop_in} <= {3'h0, !eh};
		wr(8'h28, 32'h1, OK);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end
	// Healthy readings vary every cycle unless a scenario forces a fault level
	always @(posedge aclk)
	begin
		lf <= lfsr(lf);
		oil_pressure <= oil_f ? oil_v : {6'h00, lf[9:0]} + 16'h00FA;
		coolant_temp <= cool_f ? cool_v : {10'h000, lf[15:10]} + 16'h0014;
		cyc <= cyc + 1;
		if (cyc == 30000)
		begin
			fails++;
			complete_run();
		end
	end
	initial
	begin
		lf = 32'h5446;
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, ext_shutdown} = 7'h00;
		{run_key, stop_key, ok_key, esc_key, engine_control_switch_auto, engine_control_switch_run} = 6'h00;
		{engine_control_switch_stop, oil_f, cool_f, eh, estop_in} = 5'h01;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, oil_v, cool_v} = 80'h0;
		s_axi_wstrb = 4'hF;
		oil_pressure = 16'h00FA;
		coolant_temp = 16'h0014;
		fails = 0;
		total_checks = 0;
		cyc = 0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		wr(gsp_pkg::ADDR_ACCESS, 32'h0, OK);
		for (int i = 0; i < 10; i++)
			rdc(8'(4 * i), dflt(i), OK);
		rdc(8'h2C, 32'h0, ER);
		wr(8'h30, 32'h0, ER);
		@(posedge aclk) s_axi_wstrb <= 4'h3;
		wr(gsp_pkg::ADDR_COOLDOWN, 32'h0, ER);
		@(posedge aclk) s_axi_wstrb <= 4'hF;
		rdc(gsp_pkg::ADDR_COOLDOWN, {16'h0000, gsp_pkg::COOLDOWN_RST}, OK);
		wr(gsp_pkg::ADDR_OVERSPEED, 32'h03E8, ER);
		wr(gsp_pkg::ADDR_ACCESS, 32'h7, OK);
		wr(gsp_pkg::ADDR_HOURS, 32'h64, ER);
		wr(gsp_pkg::ADDR_OVERSPEED, 32'h03E8, OK);
		wr(gsp_pkg::ADDR_ACCESS, 32'h2, OK);
		wr(gsp_pkg::ADDR_HOURS, 32'h64, ER);
		wr(gsp_pkg::ADDR_ACCESS, 32'h3, OK);
		wr(gsp_pkg::ADDR_OVERSPEED, {16'h0, gsp_pkg::OVERSPEED_RST}, OK);
		wr(gsp_pkg::ADDR_COOL, 32'h0030_0064, ER);
		wr(gsp_pkg::ADDR_COOL, 32'h0031_0064, OK);
		wr(gsp_pkg::ADDR_COOL, gsp_pkg::COOL_RST, OK);
		hv = {16'h0001, lf[15:0]};
		wr(gsp_pkg::ADDR_HOURS, hv, OK);
		wr(gsp_pkg::ADDR_HOURS, hv - 32'h1, ER);
		wr(gsp_pkg::ADDR_HOURS, HMAX + 32'h1, ER);
		rdc(gsp_pkg::ADDR_HOURS, hv, OK);
		wr(gsp_pkg::ADDR_CONFIG, 32'h6E, OK);
		wr(gsp_pkg::ADDR_DELAYS, 32'h020202, OK);
		wr(gsp_pkg::ADDR_COOLDOWN, 32'h0, OK);
		@(posedge aclk) engine_control_switch_auto <= 1'b1;
		kp(0);
		repeat (20) @(posedge aclk);
		chk(fuel_out === 1'b0, "key locked");
		@(posedge aclk) engine_control_switch_auto <= 1'b0;
		start(4);
		sv = stops;
		kp(5);
		fw(1'b0, 0, 3, "stop now");
		repeat (2) @(posedge aclk);
		chk(stops === sv + 1, "can stop");
		start(0);
		for (int i = 0; i < 3; i++)
		begin
			// First pass: oil off, coolant warn only, so shutdown-level readings must not stop
			wr(gsp_pkg::ADDR_CONFIG, i == 0 ? 32'h12 : (i == 1 ? 32'h6E : 32'hEE), OK);
			@(posedge aclk) {ext_shutdown, oil_f, oil_v, cool_f, cool_v} <= {1'b1, i == 0, 16'h0032, i == 0, 16'h0073};
			repeat (60) @(posedge aclk);
			chk(fuel_out === (i < 2), "ext response");
			@(posedge aclk) {ext_shutdown, oil_f, cool_f} <= 3'h0;
		end
		wr(8'h28, 32'h1, OK);
		wr(gsp_pkg::ADDR_CONFIG, 32'h6E, OK);
		start(0);
		@(posedge aclk) estop_in <= 1'b0;
		trip(0, 3, "estop low");
		start(0);
		wr(gsp_pkg::ADDR_OVERSPEED, 32'h03E8, OK);
		trip(0, 3, "overspeed");
		wr(gsp_pkg::ADDR_OVERSPEED, {16'h0, gsp_pkg::OVERSPEED_RST}, OK);
		start(0);
		@(posedge aclk) {oil_f, oil_v} <= {1'b1, 16'h0032};
		repeat (3) @(posedge aclk);
		chk(oil_warn === 1'b1, "oil warn");
		trip(15, 60, "oil");
		wr(gsp_pkg::ADDR_COOLDOWN, 32'h3, OK);
		start(0);
		kp(5);
		fw(1'b0, 19, 36, "cooldown");
		wr(gsp_pkg::ADDR_CONFIG, 32'hAE, OK);
		start(0);
		@(posedge aclk) ext_shutdown <= 1'b1;
		trip(19, 36, "soft");
		start(0);
		@(posedge aclk) {cool_f, cool_v} <= {1'b1, 16'h0069};
		repeat (50) @(posedge aclk);
		chk(cool_warn === 1'b1 && fuel_out === 1'b1, "cool warn");
		@(posedge aclk) cool_v <= 16'h0073;
		trip(29, 75, "cool");
		wr(gsp_pkg::ADDR_COOLDOWN, 32'h64, OK);
		start(0);
		for (int i = 0; i < 2; i++)
		begin
			@(posedge aclk) stop_key <= 1'b1;
			repeat (38) @(posedge aclk);
			#1 chk(bypass_prompt === 1'b0, "early prompt");
			repeat (16) @(posedge aclk);
			#1 chk(bypass_prompt === 1'b1, "prompt");
			kp(3 - i);
		end
		fw(1'b0, 0, 3, "bypass");
		wr(gsp_pkg::ADDR_HOURS, HMAX - 32'h1, OK);
		repeat (3700) @(posedge aclk);
		rdc(gsp_pkg::ADDR_HOURS, HMAX - 32'h1, OK);
		start(0);
		for (int i = 0; i < 2; i++)
		begin
			repeat (3700) @(posedge aclk);
			rdc(gsp_pkg::ADDR_HOURS, HMAX, OK);
		end
		eh = 1'b1;
		wr(gsp_pkg::ADDR_CONFIG, 32'hAF, OK);
		trip(0, 6, "estop high");
		start(0);
		repeat (10) @(posedge aclk);
		#1 chk(fuel_out === 1'b1, "estop idle");
		complete_run();
	end
endmodule

// File: test/gsp_engine_model.sv
// Engine and engine controller model facing the fuel and CAN stop outputs
`timescale 1ns/1ns
module gsp_engine_model (
	input wire logic aclk, // clock
	input wire logic fuel_out, // fuel enable from the sequencer
	input wire logic can_stop_req, // stop message pulse
	output logic [15:0] engine_speed, // rpm
	output int stops // stop messages received
);
	initial
	begin
		engine_speed = 16'h0000;
		stops = 0;
	end
	// Speed ramps in steps so crank terminate is crossed a few cycles after fuel
	always @(posedge aclk)
	begin
		if (can_stop_req === 1'b1)
			stops <= stops + 1;
		if (fuel_out === 1'b1 && engine_speed < 16'h0708)
			engine_speed <= engine_speed + 16'h00C8;
		else if (fuel_out !== 1'b1 && engine_speed != 16'h0000)
			engine_speed <= engine_speed - 16'h00C8;
	end
endmodule
